// file: verilog/enc_link_pkg.sv
// Package of constants shared by the encoder responder and the drive-side requester.
// Functional notes
// - Bytes are start, eight data, stop bits.
// - Data bits go lowest first.
// - Last byte is XOR of earlier bytes.
// - Command code is exactly one byte.
// - Position command returns status and position.
// - Identity command returns status and identity.
// - All-data command returns every field.
// - Parameter write stores value, replies within 20us.
// - Host stays silent awaiting write reply.
// - Parameter read returns value within 20us.
// - Host stays silent awaiting read reply.
// - Parameter reply echoes request field layout.
// - Parameters 0-0x7E per page, 0x7F page.
// - Ten fault clears spaced 62.5us clear faults.
// - Position is 17 bits over three bytes.
// - Status bit 4 mirrors counting error.
// - Fault byte bit0 overspeed, bit2 counting.
package enc_link_pkg;
  localparam int CLK_MHZ = 200;
  localparam int BAUD_KBPS = 2500;
  localparam int BIT_CYCLES = CLK_MHZ * 1000 / BAUD_KBPS;
  localparam int REPLY_US = 20;
  localparam int REPLY_CYCLES = REPLY_US * CLK_MHZ;
  localparam int GAP_NS = 62500;
  localparam int GAP_CYCLES = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int CLEAR_COUNT = 10;
  localparam logic [7:0] CMD_POS = 8'h02;
  localparam logic [7:0] CMD_IDENT = 8'h92;
  localparam logic [7:0] CMD_ALL = 8'h1A;
  localparam logic [7:0] CMD_PWRITE = 8'h32;
  localparam logic [7:0] CMD_PREAD = 8'hEA;
  localparam logic [7:0] CMD_FCLEAR = 8'hBA;
  localparam logic [6:0] PAGE_ADDR = 7'h7F;
  localparam int STATUS_CNT_BIT = 4;
  localparam int FAULT_OVS_BIT = 0;
  localparam int FAULT_CNT_BIT = 2;
  localparam int MAX_FRAME = 11;
  // Identity value is arbitrary.
  localparam logic [7:0] IDENT_VALUE = 8'h5A;

  // Request byte count for a given command, zero when unknown.
  function automatic logic [3:0] req_len(input logic [7:0] c);
    case (c)
      CMD_POS, CMD_IDENT, CMD_ALL, CMD_FCLEAR: req_len = 4'h2;
      CMD_PREAD:                               req_len = 4'h3;
      CMD_PWRITE:                              req_len = 4'h4;
      default:                                 req_len = 4'h0;
    endcase
  endfunction
endpackage

// file: verilog/enc_link_if.sv
// Interface joining the two ends over the half-duplex serial line.
`timescale 1ns/1ps
interface enc_link_if;
  logic dev_tx;
  logic dev_oe;
  logic host_tx;
  logic host_oe;
  logic line;
  // Line rests high when nobody drives.
  assign line = dev_oe ? dev_tx : (host_oe ? host_tx : 1'b1);
  modport device (output dev_tx, output dev_oe, input line);
  modport host (output host_tx, output host_oe, input line);
endinterface

// file: verilog/enc_responder.sv
// Encoder end: receives requests and sends framed replies.
`timescale 1ns/1ps
module enc_responder
  import enc_link_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  // Encoder state inputs.
  input  wire logic [16:0] i_position,
  input  wire logic        i_overspeed,
  input  wire logic        i_count_fault,
  // Serial link.
  enc_link_if.device       link,
  // Observation outputs.
  output logic [7:0]       o_fault_flags,
  output logic             o_busy
);
  typedef enum logic [3:0] {
    S_RX  = 4'b0001,
    S_DLY = 4'b0010,
    S_TX  = 4'b0100,
    S_GAP = 4'b1000
  } st_e;

  st_e         st_q;
  logic [7:0]  rxb_q [0:3];
  logic [2:0]  rxn_q;
  logic [7:0]  rx_sh_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_cnt_q;
  logic        rx_act_q;
  logic        rx_done;
  logic [7:0]  txb_q [0:MAX_FRAME-1];
  logic [3:0]  txn_q;
  logic [3:0]  txi_q;
  logic [3:0]  tx_bit_q;
  logic [7:0]  tx_cnt_q;
  logic [9:0]  tx_sh_q;
  logic        tx_q;
  logic        tx_oe_q;
  logic        tx_load;
  logic [7:0]  mem_q [0:1023];
  logic [2:0]  page_q;
  logic [7:0]  fault_q;
  logic [3:0]  clr_q;
  logic [15:0] wait_q;
  logic [7:0]  xr;
  logic [3:0]  need;
  logic [9:0]  maddr;

  // Byte receiver, LSB first, sampled mid-bit after a falling start edge.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rx_act_q <= 1'b0;
      rx_bit_q <= 4'h0;
      rx_cnt_q <= 8'h00;
      rx_sh_q  <= 8'h00;
    end else if (i_ce) begin
      if (!rx_act_q) begin
        if (!link.line && st_q == S_RX) begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= 8'(BIT_CYCLES / 2);
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q == 8'(BIT_CYCLES - 1)) begin
        rx_cnt_q <= 8'h00;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) begin
          rx_sh_q <= {link.line, rx_sh_q[7:1]};
        end
        if (rx_bit_q == 4'h9) begin
          rx_act_q <= 1'b0;
        end
      end else begin
        rx_cnt_q <= rx_cnt_q + 8'h01;
      end
    end
  end

  assign rx_done = rx_act_q && rx_bit_q == 4'h9 && rx_cnt_q == 8'(BIT_CYCLES - 1);
  assign need = req_len(rxb_q[0]);
  assign maddr = {page_q, rxb_q[1][6:0]};

  // Checksum of the collected request, excluding the last byte.
  always_comb begin
    xr = 8'h00;
    for (int i = 0; i < 3; i++) begin
      if (3'(i) < 3'(need - 4'h1)) begin
        xr = xr ^ rxb_q[i];
      end
    end
  end

  // Fault flags latch until cleared by the clear sequence.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      fault_q <= 8'h00;
    end else if (i_ce) begin
      if (st_q == S_DLY && rxb_q[0] == CMD_FCLEAR && clr_q == 4'(CLEAR_COUNT)) begin
        fault_q <= 8'h00;
      end
      if (i_overspeed) begin
        fault_q[FAULT_OVS_BIT] <= 1'b1;
      end
      if (i_count_fault) begin
        fault_q[FAULT_CNT_BIT] <= 1'b1;
      end
    end
  end

  // Frame sequencer: collect request, validate, build and send reply.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_q   <= S_RX;
      rxn_q  <= 3'h0;
      txn_q  <= 4'h0;
      wait_q <= 16'h0000;
      page_q <= 3'h0;
      clr_q  <= 4'h0;
      for (int i = 0; i < 4; i++) rxb_q[i] <= 8'h00;
      for (int i = 0; i < MAX_FRAME; i++) txb_q[i] <= 8'h00;
    end else if (i_ce) begin
      case (st_q)
        S_RX: begin
          if (rx_done) begin
            rxb_q[rxn_q[1:0]] <= rx_sh_q;
            rxn_q <= rxn_q + 3'h1;
          end else if (rxn_q != 3'h0 && {1'b0, rxn_q} == need) begin
            rxn_q <= 3'h0;
            st_q  <= S_DLY;
          end else if (rxn_q == 3'h1 && need == 4'h0) begin
            rxn_q <= 3'h0;
          end
        end
        S_DLY: begin
          st_q <= S_RX;
          if (xr == rxb_q[need[1:0] - 2'h1]) begin
            st_q   <= S_TX;
            wait_q <= 16'h0000;
            txb_q[0] <= rxb_q[0];
            txb_q[1] <= 8'h00 | ({7'h00, fault_q[FAULT_CNT_BIT]} << STATUS_CNT_BIT);
            txb_q[2] <= i_position[7:0];
            txb_q[3] <= i_position[15:8];
            txb_q[4] <= {7'h00, i_position[16]};
            clr_q <= (rxb_q[0] == CMD_FCLEAR) ? clr_q + 4'h1 : 4'h0;
            case (rxb_q[0])
              CMD_POS, CMD_FCLEAR: begin
                txn_q <= 4'h6;
                txb_q[5] <= rxb_q[0] ^ txb_q_status() ^ pos_x();
                if (clr_q + 4'h1 == 4'(CLEAR_COUNT) && rxb_q[0] == CMD_FCLEAR) begin
                  clr_q <= 4'(CLEAR_COUNT);
                  st_q  <= S_DLY;
                end
              end
              CMD_IDENT: begin
                txn_q <= 4'h4;
                txb_q[2] <= IDENT_VALUE;
                txb_q[3] <= rxb_q[0] ^ txb_q_status() ^ IDENT_VALUE;
              end
              CMD_ALL: begin
                txn_q <= 4'hB;
                txb_q[5] <= IDENT_VALUE;
                txb_q[6] <= 8'h00;
                txb_q[7] <= 8'h00;
                txb_q[8] <= 8'h00;
                txb_q[9] <= fault_q;
                txb_q[10] <= rxb_q[0] ^ txb_q_status() ^ pos_x() ^ IDENT_VALUE ^ fault_q;
              end
              CMD_PWRITE: begin
                txn_q <= 4'h4;
                txb_q[1] <= rxb_q[1];
                txb_q[2] <= rxb_q[2];
                txb_q[3] <= rxb_q[3];
              end
              default: begin
                txn_q <= 4'h4;
                txb_q[1] <= rxb_q[1];
                txb_q[2] <= (rxb_q[1][6:0] == PAGE_ADDR) ? {5'h00, page_q} : mem_q[maddr];
                txb_q[3] <= rxb_q[0] ^ rxb_q[1] ^
                            ((rxb_q[1][6:0] == PAGE_ADDR) ? {5'h00, page_q} : mem_q[maddr]);
              end
            endcase
            if (rxb_q[0] == CMD_PWRITE && rxb_q[1][6:0] == PAGE_ADDR) begin
              page_q <= rxb_q[2][2:0];
            end
          end
          if (clr_q == 4'(CLEAR_COUNT)) begin
            clr_q <= 4'h0;
            st_q  <= S_TX;
          end
        end
        S_TX: begin
          wait_q <= wait_q + 16'h0001;
          if (txi_q == txn_q && tx_bit_q == 4'h0 && wait_q > 16'h0002) begin
            st_q   <= S_GAP;
            wait_q <= 16'h0000;
          end
        end
        S_GAP: begin
          wait_q <= wait_q + 16'h0001;
          if (wait_q == 16'(BIT_CYCLES)) begin
            st_q <= S_RX;
          end
        end
        default: st_q <= S_RX;
      endcase
    end
  end

  // Parameter memory write, one flat array indexed by page and address.
  always_ff @(posedge i_mclk) begin
    if (i_ce && st_q == S_DLY && rxb_q[0] == CMD_PWRITE && xr == rxb_q[3] &&
        rxb_q[1][6:0] != PAGE_ADDR) begin
      mem_q[maddr] <= rxb_q[2];
    end
  end

  // The first byte waits one bit time so the host has released the line, the rest follow
  // back to back at the end of each stop bit.
  assign tx_load = (tx_bit_q == 4'h0) ? (txi_q == 4'h0 && wait_q >= 16'(BIT_CYCLES)) :
                   (tx_bit_q == 4'h1 && tx_cnt_q == 8'(BIT_CYCLES - 1) && txi_q != txn_q);

  // Byte transmitter: start, eight data bits LSB first, stop; drive only while framing.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      txi_q    <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_cnt_q <= 8'h00;
      tx_sh_q  <= 10'h3FF;
      tx_q     <= 1'b1;
      tx_oe_q  <= 1'b0;
    end else if (i_ce) begin
      if (st_q != S_TX) begin
        txi_q    <= 4'h0;
        tx_bit_q <= 4'h0;
        tx_q     <= 1'b1;
        tx_oe_q  <= 1'b0;
      end else if (tx_load) begin
        tx_sh_q  <= {1'b1, txb_q[txi_q], 1'b0};
        tx_bit_q <= 4'hA;
        tx_cnt_q <= 8'h00;
        tx_q     <= 1'b0;
        tx_oe_q  <= 1'b1;
        txi_q    <= txi_q + 4'h1;
      end else if (tx_bit_q != 4'h0) begin
        if (tx_cnt_q == 8'(BIT_CYCLES - 1)) begin
          tx_cnt_q <= 8'h00;
          tx_bit_q <= tx_bit_q - 4'h1;
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_q     <= tx_sh_q[1];
          tx_oe_q  <= (tx_bit_q != 4'h1); // Release right after the last stop bit.
        end else begin
          tx_cnt_q <= tx_cnt_q + 8'h01;
        end
      end
    end
  end

  // Status byte and position checksum helpers.
  function automatic logic [7:0] txb_q_status();
    txb_q_status = {3'h0, fault_q[FAULT_CNT_BIT], 4'h0};
  endfunction

  function automatic logic [7:0] pos_x();
    pos_x = i_position[7:0] ^ i_position[15:8] ^ {7'h00, i_position[16]};
  endfunction

  assign link.dev_tx   = tx_q;
  assign link.dev_oe   = tx_oe_q;
  assign o_fault_flags = fault_q;
  assign o_busy        = (st_q != S_RX);
endmodule

// file: verilog/enc_requester.sv
// Drive end: sends one request frame and collects the reply.
`timescale 1ns/1ps
module enc_requester
  import enc_link_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic       i_mclk,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  // Request side.
  input  wire logic       i_req_valid,
  input  wire logic [7:0] i_cmd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic            o_req_ready,
  // Reply side.
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_byte,
  output logic            o_timeout,
  // Serial link.
  enc_link_if.host        link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_TX   = 3'b010,
    H_RX   = 3'b100
  } hst_e;

  hst_e        st_q;
  logic [7:0]  b_q [0:3];
  logic [2:0]  n_q;
  logic [2:0]  i_q;
  logic [9:0]  sh_q;
  logic [3:0]  bit_q;
  logic [7:0]  cnt_q;
  logic        tx_q;
  logic        oe_q;
  logic [15:0] wait_q;
  logic [15:0] gap_q;
  logic        ra_q;
  logic [3:0]  rb_q;
  logic [7:0]  rc_q;
  logic [7:0]  rs_q;
  logic [3:0]  len;

  assign len = req_len(i_cmd);
  assign o_req_ready = (st_q == H_IDLE) && (gap_q >= 16'(GAP_CYCLES));

  // Request framing, silence while awaiting the reply, spacing between commands.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_q <= H_IDLE;
      n_q <= 3'h0;
      i_q <= 3'h0;
      bit_q <= 4'h0;
      cnt_q <= 8'h00;
      sh_q <= 10'h3FF;
      tx_q <= 1'b1;
      oe_q <= 1'b0;
      wait_q <= 16'h0000;
      gap_q <= 16'(GAP_CYCLES);
      o_timeout <= 1'b0;
      for (int k = 0; k < 4; k++) b_q[k] <= 8'h00;
    end else if (i_ce) begin
      o_timeout <= 1'b0;
      if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
      case (st_q)
        H_IDLE: begin
          if (i_req_valid && o_req_ready && len != 4'h0) begin
            b_q[0] <= i_cmd;
            b_q[1] <= (len == 4'h2) ? i_cmd : i_addr;
            b_q[2] <= (len == 4'h3) ? (i_cmd ^ i_addr) : i_data;
            b_q[3] <= i_cmd ^ i_addr ^ i_data;
            n_q <= len[2:0];
            i_q <= 3'h0;
            gap_q <= 16'h0000;
            st_q <= H_TX;
          end
        end
        H_TX: begin
          // Drive starts with the first start bit and ends with the last stop bit.
          if (bit_q == 4'h0) begin
            sh_q <= {1'b1, b_q[0], 1'b0};
            tx_q <= 1'b0;
            oe_q <= 1'b1;
            bit_q <= 4'hA;
            cnt_q <= 8'h00;
            i_q <= 3'h1;
          end else if (cnt_q == 8'(BIT_CYCLES - 1)) begin
            cnt_q <= 8'h00;
            if (bit_q != 4'h1) begin
              bit_q <= bit_q - 4'h1;
              sh_q <= {1'b1, sh_q[9:1]};
              tx_q <= sh_q[1];
            end else if (i_q == n_q) begin
              bit_q <= 4'h0;
              oe_q <= 1'b0;
              st_q <= H_RX;
              wait_q <= 16'h0000;
            end else begin
              sh_q <= {1'b1, b_q[i_q[1:0]], 1'b0};
              tx_q <= 1'b0;
              bit_q <= 4'hA;
              i_q <= i_q + 3'h1;
            end
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        H_RX: begin
          tx_q <= 1'b1;
          wait_q <= ra_q ? 16'h0000 : wait_q + 16'h0001;
          if (wait_q == 16'(REPLY_CYCLES + 4 * BIT_CYCLES * 10)) begin
            st_q <= H_IDLE;
            o_timeout <= 1'b1;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Reply byte receiver, LSB first.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ra_q <= 1'b0;
      rb_q <= 4'h0;
      rc_q <= 8'h00;
      rs_q <= 8'h00;
      o_rsp_valid <= 1'b0;
      o_rsp_byte <= 8'h00;
    end else if (i_ce) begin
      o_rsp_valid <= 1'b0;
      if (!ra_q) begin
        if (st_q == H_RX && !link.line) begin
          ra_q <= 1'b1;
          rc_q <= 8'(BIT_CYCLES / 2);
          rb_q <= 4'h0;
        end
      end else if (rc_q == 8'(BIT_CYCLES - 1)) begin
        rc_q <= 8'h00;
        rb_q <= rb_q + 4'h1;
        if (rb_q >= 4'h1 && rb_q <= 4'h8) rs_q <= {link.line, rs_q[7:1]};
        if (rb_q == 4'h9) begin
          ra_q <= 1'b0;
          o_rsp_valid <= 1'b1;
          o_rsp_byte <= rs_q;
        end
      end else begin
        rc_q <= rc_q + 8'h01;
      end
    end
  end

  assign link.host_tx = tx_q;
  assign link.host_oe = oe_q;
endmodule

// file: testbench/enc_link_chk.sv
// Checker of the serial line between the drive end and the encoder end.
`timescale 1ns/1ps
module enc_link_chk
  import enc_link_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_srst,
  // Line signals.
  input wire logic dev_tx,
  input wire logic dev_oe,
  input wire logic host_tx,
  input wire logic host_oe,
  input wire logic line
);
  logic        prev_q;
  logic [15:0] run_q;
  logic [15:0] frm_q;
  logic [15:0] wait_q;
  logic        pend_q;
  logic        any_oe;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  // Either end drives the line.
  assign any_oe = dev_oe | host_oe;

  // Cycles since the line last changed.
  always_ff @(posedge i_mclk) begin
    prev_q <= i_srst ? 1'b1 : line;
    run_q  <= (i_srst || line != prev_q) ? 16'h0 : run_q + 16'h1;
  end

  // Length of the current driven frame.
  always_ff @(posedge i_mclk) begin
    frm_q <= (i_srst || !any_oe) ? 16'h0 : frm_q + 16'h1;
  end

  // Wait from the end of a request to the start of its reply.
  always_ff @(posedge i_mclk) begin
    pend_q <= i_srst ? 1'b0 : ($fell(host_oe) ? 1'b1 : (dev_oe ? 1'b0 : pend_q));
    wait_q <= (i_srst || !pend_q) ? 16'h0 : wait_q + 16'h1;
  end

  property p_idle;
    !any_oe |-> line;
  endproperty
  a_idle: assert property (p_idle) else $error("line not high while idle");
  property p_one_talker;
    !(dev_oe && host_oe);
  endproperty
  a_one_talker: assert property (p_one_talker) else $error("both ends drive");
  property p_dev_start;
    $rose(dev_oe) |-> !line [*8];
  endproperty
  a_dev_start: assert property (p_dev_start) else $error("reply lacks start bit");
  property p_host_start;
    $rose(host_oe) |-> !line [*8];
  endproperty
  a_host_start: assert property (p_host_start) else $error("request lacks start bit");
  property p_bit_len;
    (line != prev_q) && $past(any_oe) |-> (run_q % BIT_CYCLES) == BIT_CYCLES - 1;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit time wrong");
  property p_frame_len;
    !any_oe && frm_q != 16'h0 |-> (frm_q % (10 * BIT_CYCLES)) == 0;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not whole bytes");
  property p_stop;
    $fell(dev_oe) || $fell(host_oe) |-> $past(line);
  endproperty
  a_stop: assert property (p_stop) else $error("frame ends without stop bit");
  property p_turn;
    $fell(host_oe) |-> !dev_oe [*8];
  endproperty
  a_turn: assert property (p_turn) else $error("reply starts too soon");
  property p_reply;
    pend_q |-> wait_q <= REPLY_CYCLES;
  endproperty
  a_reply: assert property (p_reply) else $error("reply too late");

  // Main traffic seen on the line.
  c_req: cover property ($rose(host_oe));
  c_rsp: cover property ($rose(dev_oe));
  c_wait: cover property (pend_q && wait_q > 16'h0014);
endmodule

// file: testbench/encoder_serial_responder_test.sv
// Self-checking bench joining the drive end and the encoder end.
`timescale 1ns/1ps
module encoder_serial_responder_test;
  import enc_link_pkg::*;
  logic        i_mclk      = 1'b0;
  logic        i_srst      = 1'b1;
  logic        i_req_valid = 1'b0;
  logic [7:0]  i_cmd       = 8'h00;
  logic [7:0]  i_addr      = 8'h00;
  logic [7:0]  i_data      = 8'h00;
  logic [16:0] i_position  = 17'h12345;
  logic        i_overspeed = 1'b0;
  logic        i_count_fault = 1'b0;
  logic        raw_tx      = 1'b1;
  logic        raw_oe      = 1'b0;
  logic        req_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_byte;
  logic [7:0]  fault_flags;
  logic        busy;
  logic        tmo;
  logic [7:0]  got[$];
  int          error_cnt   = 0;
  int          checked     = 0;

  enc_link_if lk1();
  enc_link_if lk2();
  // The bench plays the drive end on the second line.
  assign lk2.host_tx = raw_tx;
  assign lk2.host_oe = raw_oe;

  enc_requester enc_requester_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(1'b1),
    .i_req_valid(i_req_valid), .i_cmd(i_cmd), .i_addr(i_addr), .i_data(i_data),
    .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_byte(rsp_byte),
    .o_timeout(tmo), .link(lk1));
  enc_responder enc_responder_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(1'b1),
    .i_position(i_position), .i_overspeed(i_overspeed), .i_count_fault(i_count_fault),
    .link(lk1), .o_fault_flags(fault_flags), .o_busy());
  enc_responder enc_responder_i2 (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(1'b1),
    .i_position(i_position), .i_overspeed(i_overspeed), .i_count_fault(i_count_fault),
    .link(lk2), .o_fault_flags(), .o_busy(busy));
  enc_link_chk enc_link_chk_i (.i_mclk(i_mclk), .i_srst(i_srst), .dev_tx(lk1.dev_tx),
    .dev_oe(lk1.dev_oe), .host_tx(lk1.host_tx), .host_oe(lk1.host_oe), .line(lk1.line));

  // Free-running clock.
  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask

  // One request: the first wire byte is sampled mid-bit, then the reply is gathered.
  task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
                      input int n);
    int k;
    logic [9:0] w;
    k = 0;
    got.delete();
    while (req_ready !== 1'b1 && k < 20000) begin
      tick(1);
      k++;
    end
    if (req_ready !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t request never accepted", $time);
    end
    i_cmd = c;
    i_addr = a;
    i_data = d;
    i_req_valid = 1'b1;
    tick(1);
    i_req_valid = 1'b0;
    k = 0;
    while (lk1.line !== 1'b0 && k < 200) begin
      tick(1);
      k++;
    end
    if (lk1.line !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH %0t request start bit missing", $time);
    end
    tick(BIT_CYCLES / 2);
    for (int i = 0; i < 10; i++) begin
      w[i] = lk1.line;
      tick(BIT_CYCLES);
    end
    cmp8(w[8:1], c);
    cmp8({6'h00, w[9], w[0]}, 8'h02);
    k = 0;
    while (got.size() < n && k < 30000) begin
      if (rsp_valid === 1'b1) got.push_back(rsp_byte);
      tick(1);
      k++;
    end
  endtask

  // Compares the gathered reply with the expected bytes plus their XOR.
  task automatic frame(input logic [7:0] e[$]);
    logic [7:0] x;
    x = 8'h00;
    foreach (e[i]) x ^= e[i];
    e.push_back(x);
    cmp8(8'(got.size()), 8'(e.size()));
    foreach (e[i]) cmp8((i < got.size()) ? got[i] : 8'hXX, e[i]);
  endtask

  task automatic s_read();
    int k;
    xfer(CMD_POS, 8'h00, 8'h00, 6);
    frame('{CMD_POS, 8'h00, 8'h45, 8'h23, 8'h01});
    // The drive end gives up listening once the line stays quiet after the reply.
    k = 0;
    while (tmo !== 1'b1 && k < 9000) begin
      tick(1);
      k++;
    end
    cmp8({7'h00, tmo}, 8'h01);
    xfer(CMD_IDENT, 8'h00, 8'h00, 4);
    frame('{CMD_IDENT, 8'h00, IDENT_VALUE});
  endtask

  task automatic s_param();
    xfer(CMD_PWRITE, {1'b0, PAGE_ADDR}, 8'h05, 4);
    frame('{CMD_PWRITE, 8'h7F, 8'h05});
    xfer(CMD_PWRITE, 8'h7E, 8'hA5, 4);
    frame('{CMD_PWRITE, 8'h7E, 8'hA5});
    xfer(CMD_PREAD, 8'h7E, 8'h00, 4);
    frame('{CMD_PREAD, 8'h7E, 8'hA5});
    xfer(CMD_PREAD, 8'h7F, 8'h00, 4);
    frame('{CMD_PREAD, 8'h7F, 8'h05});
  endtask

  task automatic s_fault();
    i_overspeed = 1'b1;
    i_count_fault = 1'b1;
    tick(2);
    i_overspeed = 1'b0;
    i_count_fault = 1'b0;
    tick(2);
    cmp8(fault_flags, 8'h05);
    xfer(CMD_ALL, 8'h00, 8'h00, 11);
    frame('{CMD_ALL, 8'h10, 8'h45, 8'h23, 8'h01, IDENT_VALUE,
            8'h00, 8'h00, 8'h00, 8'h05});
  endtask

  // Nine clears keep the flags, the tenth wipes them.
  task automatic s_clear();
    for (int i = 0; i < CLEAR_COUNT; i++) begin
      xfer(CMD_FCLEAR, 8'h00, 8'h00, 6);
      tick(200);
      if (i == 0) frame('{CMD_FCLEAR, 8'h10, 8'h45, 8'h23, 8'h01});
      if (i == CLEAR_COUNT - 2) cmp8(fault_flags, 8'h05);
    end
    cmp8(fault_flags, 8'h00);
  endtask

  task automatic raw_byte(input logic [7:0] b);
    logic [9:0] s;
    s = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      raw_tx = s[i];
      tick(BIT_CYCLES);
    end
  endtask

  // Hand-made two-byte request on the second line; notes whether a reply starts.
  task automatic raw_frame(input logic [7:0] b0, input logic [7:0] b1, input logic e);
    logic seen;
    seen = 1'b0;
    raw_oe = 1'b1;
    raw_byte(b0);
    raw_byte(b1);
    raw_oe = 1'b0;
    repeat (5000) begin
      tick(1);
      if (lk2.dev_oe === 1'b1) seen = 1'b1;
    end
    cmp8({7'h00, seen}, {7'h00, e});
    cmp8({7'h00, busy}, 8'h00);
    tick(GAP_CYCLES);
  endtask

  task automatic s_drop();
    raw_frame(CMD_POS, 8'h03, 1'b0);
    raw_frame(8'h55, 8'h55, 1'b0);
    raw_frame(CMD_POS, CMD_POS, 1'b1);
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence after the reset span.
  initial begin
    tick(20);
    i_srst = 1'b0;
    tick(2);
    s_read();
    s_param();
    s_fault();
    s_clear();
    s_drop();
    complete_run();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #(400000 * 5);
    error_cnt++;
    complete_run();
  end
endmodule
